// >>> design/rx_err_pkg.sv
/*
  constants, encodings and decode functions shared by the receive
  error/status block and the bench's subframe source model.
  assumes a 125 MHz system clock and a crystal clock well below it.
*/
package rx_err_pkg;
  localparam logic [7:0] RATE_READOUT_ADDR = 8'heb;
  localparam int RATE_CODE_LSB = 4;
  localparam int RATE_COUNT_LSB = 8;
  localparam int CS_BITS = 32;
  localparam int CS_NONAUDIO_BIT = 1;
  localparam int CS_EMPH_BIT = 3;
  localparam int CS_FS_LSB = 24;
  localparam int CS_FS_MSB = 27;
  localparam logic [3:0] PAR_SHORT_MAX = 4'h8;
  localparam logic [3:0] PAR_LONG_RUN = 4'h9;
  localparam int CLK_KHZ = 125000;
  localparam int ERR_HOLD_MIN_MS = 45;
  localparam int ERR_HOLD_MIN_CYC = ERR_HOLD_MIN_MS * CLK_KHZ;
  localparam int SWITCH_WORDS = 4;
  localparam logic [7:0] RATE_CNT_MAX = 8'hff;
  localparam logic [7:0] RATE_JITTER = 8'h02;
  localparam logic [1:0] PRE_NONE = 2'h0;
  localparam logic [1:0] PRE_B = 2'h1;
  localparam logic [1:0] PRE_M = 2'h2;
  localparam logic [1:0] PRE_W = 2'h3;
  localparam logic [1:0] COND_ALL = 2'h0;
  localparam logic [1:0] COND_LOCK_ONLY = 2'h1;
  localparam logic [1:0] COND_FORCE_HIGH = 2'h2;
  localparam logic [1:0] COND_FORCE_LOW = 2'h3;

  typedef enum logic {ST_UNLOCKED, ST_LOCKED} lock_state_t;

  // count is crystal/2 cycles per word clock period
  function automatic logic [3:0] rate_code(input logic [7:0] c);
    if (c == RATE_CNT_MAX) return 4'h0;
    else if (c < 8'h21) return 4'h1;
    else if (c < 8'h31) return 4'h2;
    else if (c < 8'h43) return 4'h3;
    else if (c < 8'h63) return 4'h4;
    else if (c < 8'h85) return 4'h5;
    else if (c < 8'ha5) return 4'h6;
    else return 4'h7;
  endfunction

  function automatic logic [7:0] limit_min(input logic [1:0] lim);
    case (lim)
      2'h1: return 8'h78;
      2'h2: return 8'h3c;
      2'h3: return 8'h1e;
      default: return 8'h00;
    endcase
  endfunction
endpackage

// >>> design/hold_if.sv
/*
  carrier between the error block and its previous-sample memory.
  assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface hold_if #(parameter int W = 24);
  logic wr_en;
  logic wr_left;
  logic [W-1:0] wr_data;
  logic rd_left;
  logic [W-1:0] rd_data;
  modport user (output wr_en, output wr_left, output wr_data,
    output rd_left, input rd_data);
  modport mem (input wr_en, input wr_left, input wr_data,
    input rd_left, output rd_data);
endinterface

// >>> design/sample_hold_mem.sv
/*
  two-word store of the last good left and right samples.
  assumes read and write on one clock; read data is registered and
  shows the old word when the same slot is written in that cycle.
*/
`timescale 1ns/10ps
module sample_hold_mem #(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  hold_if.mem hb
);
  logic [W-1:0] mem_q [2];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      hb.rd_data <= '0;
    end else begin
      hb.rd_data <= mem_q[hb.rd_left];
      if (hb.wr_en) begin
        mem_q[hb.wr_left] <= hb.wr_data;
      end
    end
  end
endmodule

// >>> design/biphase_rx_error_status.sv
/*
  receive error detection, sample substitution, rate measurement and
  status pins of a biphase audio receiver.
  assumes the demodulator delivers one strobe per subframe on sys_clk;
  word clock, crystal and raw biphase lines arrive as async pins.
*/
`timescale 1ns/10ps
// Contract
// [RULE1] serial input may replace demodulated output
// [RULE2] rate measured in crystal cycles, per oscillator mode; code counts crystal/2 cycles
// [RULE3] rate code and count readable at one address
// [RULE4] error flag on lock/data error per condition
// [RULE5] unlock on biphase break or missing preamble
// [RULE6] lock error flag held minimum, word-clock aligned
// [RULE7] nine parity failures raise held error flag
// [RULE8] format option flags eight-failure runs too
// [RULE9] status or rate change acts as lock error
// [RULE10] tolerance setting masks rate change checks
// [RULE11] non-PCM error option flags and mutes output
// [RULE12] short parity runs repeat previous PCM sample
// [RULE13] mute on lock error or nine failures
// [RULE14] channel status held per bit on failure
// [RULE15] per-error output zeroing and holding
// [RULE16] relock after all preambles, resume after flag
// [RULE17] non-audio pin shows status bit one
// [RULE18] emphasis pin shows pre-emphasis status
// [RULE19] pins may carry validity and user bits
// [RULE20] burst sync only while non-PCM, may interrupt
// [RULE21] surround sync needs pattern and base frequency
// [RULE22] detection flags cleared on any error
// [RULE23] switch indicator pulses low on lock change
// [RULE24] interrupt on non-audio pin change
// [RULE25] pins updated on word clock edges only; switch pin and irq update every sys_clk
module biphase_rx_error_status #(
  parameter int HOLD_CYC = rx_err_pkg::ERR_HOLD_MIN_CYC,
  parameter int SAMPLE_W = 24,
  parameter int SW_WORDS = rx_err_pkg::SWITCH_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic recv_word_clock,
  input wire logic crystal_clock,
  input wire logic rx_biphase_in,
  input wire logic mod_biphase_in,
  input wire logic sf_strobe,
  input wire logic sf_left,
  input wire logic [1:0] sf_preamble,
  input wire logic sf_biphase_err,
  input wire logic sf_parity_err,
  input wire logic [SAMPLE_W-1:0] sf_sample,
  input wire logic sf_validity,
  input wire logic sf_user,
  input wire logic sf_cs_bit,
  input wire logic [7:0] sf_cs_index,
  input wire logic serial_audio_strobe,
  input wire logic serial_audio_left,
  input wire logic [SAMPLE_W-1:0] serial_audio_in,
  input wire logic burst_sync_seen,
  input wire logic surround_sync_seen,
  input wire logic surround_base_ok,
  input wire logic surround_ext_seen,
  input wire logic out_source_select,
  input wire logic mod_source_select,
  input wire logic nonpcm_error_enable,
  input wire logic [1:0] error_output_condition,
  input wire logic parity_flag_format,
  input wire logic rate_variation_tolerance,
  input wire logic [1:0] rate_range_limit,
  input wire logic nonaudio_or_select,
  input wire logic validity_pin_select,
  input wire logic userbit_pin_select,
  input wire logic nonpcm_irq_source,
  input wire logic osc_continuous,
  input wire logic [7:0] rd_addr,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic [SAMPLE_W-1:0] out_sample,
  output logic out_left,
  output logic out_strobe,
  output logic [SAMPLE_W-1:0] mod_sample,
  output logic mod_strobe,
  output logic biphase_monitor_out,
  output logic recv_error_flag,
  output logic nonaudio_pin,
  output logic emphasis_flag_pin,
  output logic [31:0] cs_status_out,
  output logic burst_flag,
  output logic surround_flag,
  output logic surround_ext_flag,
  output logic nonpcm_irq,
  output logic clock_switch_indicator_b
);
  // pin synchronisers: word clock, crystal, rx line, modulator line
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end else begin
      pin_s1_q <= {mod_biphase_in, rx_biphase_in, crystal_clock,
                   recv_word_clock};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire wclk_rise = pin_s2_q[0] & ~pin_s3_q[0];
  wire xtal_rise = pin_s2_q[1] & ~pin_s3_q[1];

  // lock tracking
  rx_err_pkg::lock_state_t lock_q;
  logic [2:0] pre_seen_q;
  logic cs_change, rate_change, range_err;
  wire locked = (lock_q == rx_err_pkg::ST_LOCKED);
  wire sf_break = sf_strobe & (sf_biphase_err |
                  sf_preamble == rx_err_pkg::PRE_NONE); // RULE5
  wire lock_loss = sf_break | cs_change | rate_change | range_err; // RULE9
  wire [2:0] pre_now = {sf_preamble == rx_err_pkg::PRE_W,
                        sf_preamble == rx_err_pkg::PRE_M,
                        sf_preamble == rx_err_pkg::PRE_B};
  wire [2:0] pre_seen_d = pre_seen_q | (sf_strobe ? pre_now : 3'h0);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= rx_err_pkg::ST_UNLOCKED;
      pre_seen_q <= 3'h0;
    end else begin
      case (lock_q)
        rx_err_pkg::ST_UNLOCKED: begin
          pre_seen_q <= sf_break ? 3'h0 : pre_seen_d;
          if (!sf_break && &pre_seen_d) begin
            lock_q <= rx_err_pkg::ST_LOCKED; // RULE16
          end
        end
        rx_err_pkg::ST_LOCKED: begin
          pre_seen_q <= 3'h0;
          if (lock_loss) begin
            lock_q <= rx_err_pkg::ST_UNLOCKED; // RULE5
          end
        end
        default: lock_q <= rx_err_pkg::ST_UNLOCKED;
      endcase
    end
  end

  // parity run length, saturating at the long-run mark
  logic [3:0] par_run_q;
  wire par_fail = sf_strobe & locked & sf_parity_err;
  wire long_par = par_run_q >= rx_err_pkg::PAR_LONG_RUN;
  wire [3:0] par_thr = parity_flag_format ? rx_err_pkg::PAR_SHORT_MAX
                       : rx_err_pkg::PAR_LONG_RUN; // RULE8
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_run_q <= 4'h0;
    end else if (!locked || (sf_strobe && !sf_parity_err)) begin
      par_run_q <= 4'h0;
    end else if (par_fail && !long_par) begin
      par_run_q <= par_run_q + 4'h1; // RULE7
    end
  end

  // channel status: a failed subframe leaves its bit untouched
  logic [31:0] cs_work_q;
  logic [3:0] cs_fs_q;
  logic cs_seen_q;
  wire cs_take = sf_strobe & sf_left & ~sf_parity_err &
                 (sf_cs_index < 8'(rx_err_pkg::CS_BITS));
  wire block_start = sf_strobe & locked &
                     (sf_preamble == rx_err_pkg::PRE_B);
  wire [3:0] cs_fs_now = cs_work_q[rx_err_pkg::CS_FS_MSB:
                                   rx_err_pkg::CS_FS_LSB];
  assign cs_change = block_start & cs_seen_q & (cs_fs_now != cs_fs_q);
  wire nonaudio = cs_work_q[rx_err_pkg::CS_NONAUDIO_BIT];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_work_q <= 32'h0;
      cs_fs_q <= 4'h0;
      cs_seen_q <= 1'b0;
    end else begin
      if (cs_take) begin
        cs_work_q[sf_cs_index[4:0]] <= sf_cs_bit; // RULE14
      end
      if (!locked) begin
        cs_seen_q <= 1'b0;
      end else if (block_start) begin
        cs_fs_q <= cs_fs_now; // RULE9
        cs_seen_q <= 1'b1;
      end
    end
  end

  // rate measurement: crystal/2 edges per word clock period
  logic xdiv_q, auto_done_q, meas_valid_q, err_raw_q, recv_err_q;
  logic [7:0] xcnt_q, meas_q;
  wire measuring = osc_continuous | (recv_err_q & ~auto_done_q); // RULE2
  wire meas_take = wclk_rise & measuring;
  wire [7:0] meas_diff = (xcnt_q > meas_q) ? xcnt_q - meas_q
                         : meas_q - xcnt_q;
  assign rate_change = meas_take & meas_valid_q & locked &
                       ~rate_variation_tolerance &
                       (meas_diff > rx_err_pkg::RATE_JITTER); // RULE10
  assign range_err = meas_valid_q & locked & ~rate_variation_tolerance &
                     (meas_q < rx_err_pkg::limit_min(rate_range_limit));
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xdiv_q <= 1'b0;
      xcnt_q <= 8'h0;
      meas_q <= 8'h0;
      meas_valid_q <= 1'b0;
      auto_done_q <= 1'b0;
    end else begin
      if (xtal_rise) begin
        xdiv_q <= ~xdiv_q;
      end
      if (wclk_rise) begin
        xcnt_q <= 8'h0;
      end else if (xtal_rise && xdiv_q &&
                   xcnt_q != rx_err_pkg::RATE_CNT_MAX) begin
        xcnt_q <= xcnt_q + 8'h1;
      end
      if (meas_take) begin
        meas_q <= xcnt_q;
        meas_valid_q <= 1'b1;
      end
      if (!locked) begin
        auto_done_q <= 1'b0;
      end else if (!err_raw_q && recv_err_q) begin
        auto_done_q <= 1'b1; // RULE2
      end
    end
  end

  // error cause and minimum hold
  wire nonpcm_cause = nonpcm_error_enable & nonaudio & locked; // RULE11
  wire data_cause = (par_run_q >= par_thr) | nonpcm_cause;
  logic err_cause;
  always_comb begin
    case (error_output_condition)
      rx_err_pkg::COND_ALL: err_cause = ~locked | data_cause; // RULE4
      rx_err_pkg::COND_LOCK_ONLY: err_cause = ~locked;
      rx_err_pkg::COND_FORCE_HIGH: err_cause = 1'b1;
      default: err_cause = 1'b0;
    endcase
  end
  logic [31:0] hold_cnt_q;
  wire hold_done = hold_cnt_q >= 32'(HOLD_CYC);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_raw_q <= 1'b1;
      hold_cnt_q <= 32'h0;
    end else if (err_cause) begin
      err_raw_q <= 1'b1; // RULE7
      hold_cnt_q <= 32'h0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 32'h1; // RULE6
    end else begin
      err_raw_q <= 1'b0;
    end
  end

  // subframe pipeline with previous-sample substitution
  hold_if #(.W(SAMPLE_W)) hb ();
  sample_hold_mem #(.W(SAMPLE_W)) u_hold (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .hb(hb)
  );
  assign hb.wr_en = sf_strobe & locked & ~sf_parity_err;
  assign hb.wr_left = sf_left;
  assign hb.wr_data = sf_sample;
  assign hb.rd_left = sf_left;
  wire sf_mute = ~locked | lock_loss | long_par |
                 (par_fail && par_run_q >= rx_err_pkg::PAR_SHORT_MAX) |
                 nonpcm_cause | recv_err_q; // RULE13
  wire sf_sub = par_fail & ~nonaudio; // RULE12
  logic p_strobe_q, p_left_q, p_mute_q, p_sub_q, p_long_q;
  logic [SAMPLE_W-1:0] p_sample_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_strobe_q <= 1'b0;
      p_left_q <= 1'b0;
      p_mute_q <= 1'b1;
      p_sub_q <= 1'b0;
      p_long_q <= 1'b0;
      p_sample_q <= '0;
    end else begin
      p_strobe_q <= sf_strobe & ~out_source_select;
      p_left_q <= sf_left;
      p_mute_q <= sf_mute;
      p_sub_q <= sf_sub;
      p_long_q <= long_par | ~locked;
      p_sample_q <= sf_sample;
    end
  end
  wire [SAMPLE_W-1:0] demod_word = p_mute_q ? '0 :
                                   p_sub_q ? hb.rd_data : p_sample_q;
  wire serial_out = out_source_select & serial_audio_strobe;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sample <= '0;
      out_left <= 1'b0;
      out_strobe <= 1'b0;
      mod_sample <= '0;
      mod_strobe <= 1'b0;
      biphase_monitor_out <= 1'b0;
    end else begin
      out_strobe <= serial_out | p_strobe_q;
      if (serial_out) begin
        out_sample <= serial_audio_in; // RULE1
        out_left <= serial_audio_left;
      end else if (p_strobe_q) begin
        out_sample <= demod_word; // RULE15
        out_left <= p_left_q;
      end
      mod_strobe <= mod_source_select & serial_audio_strobe;
      if (mod_source_select && serial_audio_strobe) begin
        mod_sample <= serial_audio_in; // RULE1
      end
      biphase_monitor_out <= mod_source_select ? pin_s2_q[3]
                             : pin_s2_q[2];
    end
  end

  // compressed-stream detection, error clears win over new syncs
  wire det_clear = ~locked | lock_loss | data_cause | ~nonaudio; // RULE22
  logic burst_q, surr_q, ext_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_q <= 1'b0;
      surr_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      burst_q <= ~det_clear & (burst_q | burst_sync_seen); // RULE20
      surr_q <= ~(det_clear & nonaudio) & ~(~locked | data_cause) &
                (surr_q | (surround_sync_seen & surround_base_ok)); // RULE21
      ext_q <= ~(~locked | data_cause) &
               (ext_q | (surr_q & surround_ext_seen)); // RULE21
    end
  end

  // status pins advance on word clock edges; switch pin and irq update every sys_clk, switch pulse starts on lock change and counts down on word clock edges
  logic [7:0] sw_cnt_q;
  logic lock_prev_q, na_prev_q;
  wire na_raw = nonaudio | (nonaudio_or_select & (burst_q | surr_q));
  wire v_ok = locked & ~long_par;
  logic v_q, u_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      v_q <= 1'b0;
      u_q <= 1'b0;
    end else if (sf_strobe) begin
      v_q <= sf_validity & v_ok; // RULE15
      u_q <= sf_user & v_ok;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      recv_err_q <= 1'b1;
      nonaudio_pin <= 1'b0;
      emphasis_flag_pin <= 1'b0;
      cs_status_out <= 32'h0;
      burst_flag <= 1'b0;
      surround_flag <= 1'b0;
      surround_ext_flag <= 1'b0;
    end else if (wclk_rise) begin
      recv_err_q <= err_raw_q; // RULE25
      nonaudio_pin <= validity_pin_select ? v_q : na_raw; // RULE17 RULE19
      emphasis_flag_pin <= userbit_pin_select ? u_q
                           : cs_work_q[rx_err_pkg::CS_EMPH_BIT]; // RULE18
      cs_status_out <= v_ok ? cs_work_q : 32'h0; // RULE15
      burst_flag <= burst_q;
      surround_flag <= surr_q;
      surround_ext_flag <= ext_q;
    end
  end
  assign recv_error_flag = recv_err_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_prev_q <= 1'b0;
      na_prev_q <= 1'b0;
      sw_cnt_q <= 8'h0;
      clock_switch_indicator_b <= 1'b1;
      nonpcm_irq <= 1'b0;
      rd_data <= 16'h0;
    end else begin
      lock_prev_q <= locked;
      na_prev_q <= nonaudio_pin;
      if (locked != lock_prev_q) begin
        sw_cnt_q <= 8'(SW_WORDS); // RULE23
      end else if (wclk_rise && sw_cnt_q != 8'h0) begin
        sw_cnt_q <= sw_cnt_q - 8'h1;
      end
      clock_switch_indicator_b <= (sw_cnt_q == 8'h0) &
                                  (locked == lock_prev_q);
      nonpcm_irq <= nonpcm_irq_source & ((nonaudio_pin != na_prev_q) |
                    (burst_q & ~burst_flag & wclk_rise) |
                    (surr_q & ~surround_flag & wclk_rise)); // RULE24
      if (rd_en && rd_addr == rx_err_pkg::RATE_READOUT_ADDR) begin
        rd_data <= locked ? {meas_q, rx_err_pkg::rate_code(meas_q),
                             4'h0} : 16'h0; // RULE3
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_err_word_align: assert property ( // RULE6
    $changed(recv_err_q) |-> $past(wclk_rise))
    else $error("error flag moved off a word clock edge");
  a_err_hold_min: assert property ( // RULE7
    $fell(recv_err_q) |-> $past(hold_done, 2))
    else $error("error flag released before minimum hold");
  a_unlock_break: assert property ( // RULE5
    (sf_strobe && sf_biphase_err) |=> !locked)
    else $error("biphase break did not unlock");
  a_long_par_mute: assert property ( // RULE13
    (p_strobe_q && p_long_q && !out_source_select) |=> out_sample == '0)
    else $error("long parity run not muted");
  a_sub_previous: assert property ( // RULE12
    (p_strobe_q && p_sub_q && !p_mute_q && !serial_out)
    |=> out_sample == $past(hb.rd_data))
    else $error("failed sample not replaced by previous");
  a_serial_route: assert property ( // RULE1
    serial_out |=> out_strobe && out_sample == $past(serial_audio_in))
    else $error("serial input not routed to output");
  a_rate_read: assert property ( // RULE3
    (rd_en && rd_addr == rx_err_pkg::RATE_READOUT_ADDR && locked)
    |=> rd_data[15:8] == $past(meas_q) && rd_data[3:0] == 4'h0)
    else $error("rate readout wrong");
  a_flags_clear: assert property ( // RULE22
    !locked |=> !burst_q && !surr_q && !ext_q)
    else $error("detection flags survived unlock");
  a_switch_pulse: assert property ( // RULE23
    (locked != lock_prev_q) |=> !clock_switch_indicator_b)
    else $error("no switch pulse on lock change");
endmodule

// >>> tb/biphase_src_model.sv
/*
  far-side source model: framed subframes plus word clock.
  assumes inputs change at falling edges of sys_clk.
*/
`timescale 1ns/10ps
module biphase_src_model (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [31:0] cs_word,
  input wire logic [5:0] bad_count,
  input wire logic bad_load,
  input wire logic break_on,
  output logic recv_word_clock,
  output logic sf_strobe,
  output logic sf_left,
  output logic [1:0] sf_preamble,
  output logic sf_biphase_err,
  output logic sf_parity_err,
  output logic [23:0] sf_sample,
  output logic sf_validity,
  output logic sf_user,
  output logic sf_cs_bit,
  output logic [7:0] sf_cs_index
);
  logic [3:0] ph = 4'h0;
  logic [7:0] frm = 8'h00;
  logic [7:0] idx = 8'h00;
  logic [5:0] bad_left = 6'h00;
  wire logic go = run && (ph == 4'h2 || ph == 4'ha);
  // word clock stands still low outside a run
  assign recv_word_clock = run & ~ph[3];
  initial begin
    {sf_strobe, sf_left, sf_preamble, sf_biphase_err, sf_parity_err} = '0;
    {sf_sample, sf_validity, sf_user, sf_cs_bit, sf_cs_index} = '0;
  end
  // load on the rising edge so a falling-edge request never races it
  always @(posedge sys_clk) begin
    if (bad_load) bad_left <= bad_count;
    else if (sf_strobe && bad_left != 6'h00) bad_left <= bad_left - 6'h01;
  end
  always @(negedge sys_clk) begin
    sf_strobe <= go;
    if (go) begin
      sf_left <= ~ph[3];
      sf_preamble <= ph[3] ? rx_err_pkg::PRE_W :
        (idx == 8'h00 ? rx_err_pkg::PRE_B : rx_err_pkg::PRE_M);
      sf_parity_err <= bad_left != 6'h00;
      sf_sample <= {ph[3] ? 8'hb2 : 8'ha1, 8'h00, frm};
      sf_cs_bit <= idx < 8'h20 && cs_word[idx[4:0]];
      sf_cs_index <= idx;
      sf_biphase_err <= break_on;
    end else begin
      // sample is stale between strobes, so it keeps flipping
      sf_sample <= ~sf_sample;
    end
    if (run) ph <= ph + 4'h1;
    if (run && ph == 4'hf) begin
      frm <= frm + 8'h01;
      idx <= idx == 8'hbf ? 8'h00 : idx + 8'h01;
    end
  end
endmodule

// >>> tb/biphase_rx_error_status_tb_top.sv
/*
  self-checking bench for the receive error/status block.
  assumes the source model beside it; hold count shortened to 200.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module biphase_rx_error_status_tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, crystal_clock = 1'b0;
  logic run, bad_load, break_on, clock_switch_indicator_seen, irq_seen, rd_en, out_left;
  logic out_strobe;
  logic [5:0] bad_count;
  logic [31:0] cs_word, cs_status_out;
  logic [15:0] v, rd_data;
  int n_fail = 0, n_checks = 0;
  logic recv_word_clock, sf_strobe, sf_left, sf_biphase_err, sf_parity_err;
  logic [1:0] sf_preamble, error_output_condition, rate_range_limit;
  logic [23:0] prev, sf_sample, serial_audio_in, out_sample, mod_sample;
  logic sf_validity, sf_user, sf_cs_bit, serial_audio_strobe;
  logic [7:0] sf_cs_index, rd_addr;
  logic serial_audio_left, rx_biphase_in, mod_biphase_in, burst_sync_seen;
  logic surround_sync_seen, surround_base_ok, surround_ext_seen;
  logic out_source_select, mod_source_select, nonpcm_error_enable;
  logic parity_flag_format, rate_variation_tolerance, nonaudio_or_select;
  logic validity_pin_select, userbit_pin_select, nonpcm_irq_source;
  logic osc_continuous, mod_strobe, biphase_monitor_out, recv_error_flag;
  logic nonaudio_pin, emphasis_flag_pin, burst_flag, surround_flag;
  logic surround_ext_flag, nonpcm_irq, clock_switch_indicator_b;

  biphase_rx_error_status #(.HOLD_CYC(200)) dut (.*);
  biphase_src_model src (.*);

  always #4 sys_clk = ~sys_clk;
  always #20 crystal_clock = ~crystal_clock;
  always @(posedge sys_clk) begin
    if (clock_switch_indicator_b === 1'b0) clock_switch_indicator_seen <= 1'b1;
    if (nonpcm_irq === 1'b1) irq_seen <= 1'b1;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask
  task automatic wait_flag(input logic val, input int lim);
    for (int i = 0; i < lim && recv_error_flag !== val; i++)
      @(negedge sys_clk);
    if (recv_error_flag !== val) give_up();
  endtask
  task automatic wait_out(input logic side);
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      if (out_strobe === 1'b1 && out_left === side) return;
    end
    give_up();
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    rd_addr = a;
    rd_en = 1'b1;
    @(negedge sys_clk);
    rd_en = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic bad(input logic [5:0] n);
    bad_count = n;
    bad_load = 1'b1;
    @(negedge sys_clk);
    bad_load = 1'b0;
  endtask

  initial begin
    {run, bad_load, break_on, clock_switch_indicator_seen, irq_seen, rd_en} = '0;
    rx_biphase_in = 1'b0;
    {serial_audio_strobe, serial_audio_left, mod_biphase_in} = '0;
    {burst_sync_seen, surround_sync_seen, surround_base_ok} = '0;
    {surround_ext_seen, out_source_select, mod_source_select} = '0;
    {nonpcm_error_enable, parity_flag_format, nonaudio_or_select} = '0;
    {rate_variation_tolerance, validity_pin_select} = '0;
    {userbit_pin_select, error_output_condition, rate_range_limit} = '0;
    {nonpcm_irq_source, osc_continuous} = 2'h3;
    {bad_count, cs_word, serial_audio_in, rd_addr} = '0;
    repeat (5) @(negedge sys_clk);
    `CHK(recv_error_flag, 1'b1)
    `CHK(clock_switch_indicator_b, 1'b1)
    rst_b = 1'b1;
    rd(8'heb);
    `CHK(rd_data, 16'h0000)
    run = 1'b1;
    wait_flag(1'b0, 3000);
    `CHK(clock_switch_indicator_seen, 1'b1)
    rd(8'heb);
    `CHK(rd_data[3:0], 4'h0)
    `CHK(rd_data[7:4], 4'h1)
    v = rd_data;
    rd(8'h00);
    `CHK(rd_data, v)
    // one failed right subframe: the prior frame's right comes back
    wait_out(1'b0);
    prev = out_sample;
    wait_out(1'b1);
    bad(6'h01);
    wait_out(1'b0);
    `CHK(out_sample, prev)
    `CHK(recv_error_flag, 1'b0)
    `CHK(nonaudio_pin, 1'b0)
    irq_seen = 1'b0;
    cs_word = 32'h0000000a;
    repeat (7000) @(negedge sys_clk);
    `CHK(nonaudio_pin, 1'b1)
    `CHK(emphasis_flag_pin, 1'b1)
    `CHK(irq_seen, 1'b1)
    `CHK(cs_status_out, 32'h0000000a)
    nonpcm_error_enable = 1'b1;
    wait_flag(1'b1, 100);
    wait_out(1'b0);
    `CHK(out_sample, 24'h000000)
    nonpcm_error_enable = 1'b0;
    wait_flag(1'b0, 400);
    {burst_sync_seen, surround_sync_seen, surround_base_ok} = 3'h7;
    surround_ext_seen = 1'b1;
    repeat (40) @(negedge sys_clk);
    {burst_sync_seen, surround_sync_seen, surround_base_ok} = 3'h0;
    surround_ext_seen = 1'b0;
    `CHK(burst_flag, 1'b1)
    `CHK(surround_flag, 1'b1)
    `CHK(surround_ext_flag, 1'b1)
    bad(6'h14);
    wait_flag(1'b1, 600);
    wait_out(1'b0);
    `CHK(out_sample, 24'h000000)
    repeat (20) @(negedge sys_clk);
    `CHK(burst_flag, 1'b0)
    `CHK(surround_flag, 1'b0)
    `CHK(surround_ext_flag, 1'b0)
    `CHK(cs_status_out, 32'h00000000)
    repeat (150) @(negedge sys_clk);
    `CHK(recv_error_flag, 1'b1)
    wait_flag(1'b0, 4000);
    // biphase break: unlock, mute, zero readout, relock on all preambles
    break_on = 1'b1;
    wait_flag(1'b1, 100);
    wait_out(1'b0);
    `CHK(out_sample, 24'h000000)
    `CHK(nonaudio_pin, 1'b1)
    rd(8'heb);
    `CHK(rd_data, 16'h0000)
    break_on = 1'b0;
    wait_flag(1'b0, 4000);
    out_source_select = 1'b1;
    mod_source_select = 1'b1;
    serial_audio_in = 24'h5a5a5a;
    serial_audio_left = 1'b1;
    serial_audio_strobe = 1'b1;
    mod_biphase_in = 1'b1;
    @(negedge sys_clk);
    serial_audio_strobe = 1'b0;
    `CHK(mod_strobe, 1'b1)
    if (out_strobe !== 1'b1) wait_out(1'b1);
    `CHK(out_sample, 24'h5a5a5a)
    `CHK(mod_sample, 24'h5a5a5a)
    repeat (4) @(negedge sys_clk);
    `CHK(biphase_monitor_out, 1'b1)
    final_report();
  end
endmodule
